// File: src/irq_gpio_ctrl.sv
/*
  Interrupt controller and eight-pin general purpose controller.
  Assumes a byte register port on the link clock, event inputs from logic on
  core_clk, and pin levels arriving asynchronously from the pads.
*/
`timescale 1ns/1ps

module irq_gpio_ctrl
  import irq_gpio_pkg::*;
#(
  parameter int PULSE_LEN = irq_gpio_pkg::PULSE_CYCLES
) (
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  input  wire logic                         link_clk,
  input  wire logic                         reg_req,
  input  wire irq_gpio_pkg::reg_cmd_type    reg_cmd,
  output logic                              reg_busy,
  output logic                              reg_rvalid,
  output logic [7:0]                        reg_rdata,
  input  wire irq_gpio_pkg::sys_events_type sys_events,
  input  wire logic [3:0]                   pwm_out,
  input  wire logic [3:0]                   alternate_function_bits,
  input  wire logic [7:0]                   touch_status,
  input  wire logic [7:0]                   pin_in,
  output logic [7:0]                        pin_out,
  output logic [7:0]                        pin_oe,
  output logic                              irq_pin
);
  import irq_gpio_pkg::*;

  localparam logic [PULSE_CNT_WIDTH-1:0] PULSE_LOAD = PULSE_CNT_WIDTH'(PULSE_LEN);

  // Set wins over a clear landing in the same cycle
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
                                     input logic [7:0] set);
    w1c = (cur & ~clr) | set;
  endfunction

  link_state_type l_reg;
  link_state_type l_next;
  core_state_type c_reg;
  core_state_type c_next;

  logic [7:0] pin_change;
  logic [7:0] src_set;
  logic [7:0] read_byte;
  logic       access;
  logic       wr;
  logic       pending;
  logic       new_event;
  logic       irq_act;

  ////////////////////////////////////////////////////////////////////////////
  // Link side: holds the command stable until the core answers
  always_comb begin
    l_next           = l_reg;
    l_next.ack_sync1 = c_reg.ack_tgl;
    l_next.ack_sync2 = l_reg.ack_sync1;
    l_next.rvalid    = 1'b0;
    if (!l_reg.busy && reg_req) begin
      l_next.cmd     = reg_cmd;
      l_next.req_tgl = ~l_reg.req_tgl;
      l_next.busy    = 1'b1;
    end else if (l_reg.busy && (l_reg.ack_sync2 == l_reg.req_tgl)) begin
      // Core read data settled two link edges before the ack arrives
      l_next.busy   = 1'b0;
      l_next.rvalid = 1'b1;
      l_next.rdata  = c_reg.rdata;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign reg_busy   = l_reg.busy;
  assign reg_rvalid = l_reg.rvalid;
  assign reg_rdata  = l_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Core side
  assign access     = c_reg.req_sync2 != c_reg.req_seen;
  assign wr         = access && l_reg.cmd.write;
  assign pin_change = c_reg.pin_sync2 ^ c_reg.pin_prev;
  assign src_set    = {|(pin_change & c_reg.pin_irq_allow_bits),
                       sys_events.pwm_done,
                       sys_events.active_to_sleep_event |
                       sys_events.sleep_to_active_event |
                       sys_events.calibration_done,
                       sys_events.queue_data_ready,
                       !c_reg.por_done};
  assign pending    = c_reg.ctrl[CTRL_GLOBAL_EN_BIT] &&
                      |(c_reg.src_sta & c_reg.src_en);
  assign new_event  = c_reg.ctrl[CTRL_GLOBAL_EN_BIT] && |(src_set & c_reg.src_en);
  assign irq_act    = c_reg.ctrl[CTRL_PULSE_BIT] ?
                      (c_reg.ctrl[CTRL_GLOBAL_EN_BIT] && c_reg.pulse_cnt != '0) :
                      pending;

  always_comb begin
    case (l_reg.cmd.addr)
      OFS_IRQ_OUTPUT_CONTROL: read_byte = c_reg.ctrl;
      OFS_IRQ_SOURCE_ENABLE:  read_byte = c_reg.src_en;
      OFS_IRQ_SOURCE_STATUS:  read_byte = c_reg.src_sta;
      OFS_PIN_IRQ_ENABLE:     read_byte = c_reg.pin_irq_allow_bits;
      OFS_PIN_IRQ_STATUS:     read_byte = c_reg.pin_irq_flag_bits;
      OFS_PIN_LEVEL_LOW:      read_byte = c_reg.pin_sync2;
      OFS_PIN_DRIVE_LOW:      read_byte = c_reg.drive;
      OFS_PIN_DIRECTION_LOW:  read_byte = c_reg.dir;
      OFS_PIN_FUNCTION_LOW:   read_byte = c_reg.func;
      default:                read_byte = 8'h00;  // High halves and unmapped
    endcase
  end

  always_comb begin
    c_next           = c_reg;
    c_next.pin_sync1 = pin_in;
    c_next.pin_sync2 = c_reg.pin_sync1;
    c_next.pin_prev  = c_reg.pin_sync2;
    c_next.req_sync1 = l_reg.req_tgl;
    c_next.req_sync2 = c_reg.req_sync1;
    c_next.por_done  = 1'b1;
    if (access) begin
      c_next.req_seen = c_reg.req_sync2;
      c_next.ack_tgl  = ~c_reg.ack_tgl;
      c_next.rdata    = read_byte;
    end
    c_next.src_sta = w1c(c_reg.src_sta,
                         (wr && l_reg.cmd.addr == OFS_IRQ_SOURCE_STATUS) ?
                         l_reg.cmd.wdata : 8'h00, src_set);
    c_next.pin_irq_flag_bits = w1c(c_reg.pin_irq_flag_bits,
                         (wr && l_reg.cmd.addr == OFS_PIN_IRQ_STATUS) ?
                         l_reg.cmd.wdata : 8'h00, pin_change);
    if (wr) begin
      case (l_reg.cmd.addr)
        OFS_IRQ_OUTPUT_CONTROL: c_next.ctrl = l_reg.cmd.wdata & CTRL_WRITE_MASK;
        OFS_IRQ_SOURCE_ENABLE:  c_next.src_en = l_reg.cmd.wdata;
        OFS_PIN_IRQ_ENABLE:     c_next.pin_irq_allow_bits = l_reg.cmd.wdata;
        OFS_PIN_DRIVE_LOW:      c_next.drive = l_reg.cmd.wdata;
        OFS_PIN_DIRECTION_LOW:  c_next.dir = l_reg.cmd.wdata;
        OFS_PIN_FUNCTION_LOW:   c_next.func = l_reg.cmd.wdata;
        default: ;  // Monitor, high halves and unmapped ignore writes
      endcase
    end
    // A fresh event restarts the pulse rather than stretching a train
    if (c_reg.ctrl[CTRL_PULSE_BIT] && new_event) begin
      c_next.pulse_cnt = PULSE_LOAD;
    end else if (c_reg.pulse_cnt != '0) begin
      c_next.pulse_cnt = c_reg.pulse_cnt - 1'b1;
    end
    c_next.irq_pin = c_reg.ctrl[CTRL_POLARITY_BIT] ? irq_act : !irq_act;
    for (int i = 0; i < 8; i++) begin
      if (!c_reg.func[i]) begin
        c_next.pin_out[i] = touch_status[i];
      end else if (i < PWM_PIN_COUNT && alternate_function_bits[i % PWM_PIN_COUNT]) begin
        c_next.pin_out[i] = pwm_out[i % PWM_PIN_COUNT];
      end else begin
        c_next.pin_out[i] = c_reg.drive[i];
      end
    end
    c_next.pin_oe = c_reg.dir;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      c_reg         <= '0;
      c_reg.irq_pin <= 1'b1;  // Active-low idle after reset
    end else begin
      c_reg <= c_next;
    end
  end

  assign pin_out = c_reg.pin_out;
  assign pin_oe  = c_reg.pin_oe;
  assign irq_pin = c_reg.irq_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_polarity_map: assert property (
    1'b1 |=> irq_pin == ($past(c_reg.ctrl[CTRL_POLARITY_BIT]) ? $past(irq_act)
                                                              : !$past(irq_act)))
    else $error("Interrupt pin level does not follow polarity");

  a_level_hold: assert property (
    !c_reg.ctrl[CTRL_PULSE_BIT] && pending |-> irq_act)
    else $error("Level interrupt not held while pending");

  a_pulse_width: assert property (
    c_reg.ctrl[CTRL_PULSE_BIT] && c_reg.ctrl[CTRL_GLOBAL_EN_BIT] && new_event &&
    PULSE_LEN > 8 ##1 (c_reg.ctrl[CTRL_PULSE_BIT] && c_reg.ctrl[CTRL_GLOBAL_EN_BIT])[*8]
    |-> irq_act)
    else $error("Interrupt pulse ended too early");

  a_global_block: assert property (
    !c_reg.ctrl[CTRL_GLOBAL_EN_BIT] |=> irq_pin == !$past(c_reg.ctrl[CTRL_POLARITY_BIT]))
    else $error("Interrupt asserted while globally disabled");

  a_source_gate: assert property (
    !c_reg.ctrl[CTRL_PULSE_BIT] && (c_reg.src_sta & c_reg.src_en) == 8'h00 |-> !irq_act)
    else $error("Disabled source asserted the interrupt");

  a_status_sets: assert property (
    src_set[SRC_SYSTEM_BIT] |=> c_reg.src_sta[SRC_SYSTEM_BIT])
    else $error("System event not recorded in status");

  a_status_clear: assert property (
    wr && l_reg.cmd.addr == OFS_IRQ_SOURCE_STATUS && l_reg.cmd.wdata[SRC_QUEUE_BIT] &&
    !sys_events.queue_data_ready |=> !c_reg.src_sta[SRC_QUEUE_BIT])
    else $error("Write one did not clear status bit");

  a_pwm_flag: assert property (
    sys_events.pwm_done[3] |=> c_reg.src_sta[SRC_PWM_LSB + 3])
    else $error("PWM completion not recorded");

  a_pin_flag: assert property (
    c_reg.pin_sync2[0] != c_reg.pin_prev[0] |=> c_reg.pin_irq_flag_bits[0])
    else $error("Pin transition not flagged");

  a_pin_summary: assert property (
    |(pin_change & c_reg.pin_irq_allow_bits) |=> c_reg.src_sta[SRC_PIN_BIT])
    else $error("Enabled pin transition not summarised");

  a_dir_enable: assert property (
    1'b1 |=> pin_oe == $past(c_reg.dir))
    else $error("Output enable does not follow direction");

  a_link_answer: assert property (@(posedge link_clk) disable iff (!arst_n)
    !reg_busy && reg_req |=> reg_busy ##[1:40] reg_rvalid)
    else $error("Register access not answered in time");

  a_level_drop: assert property (
    !c_reg.ctrl[CTRL_PULSE_BIT] && !pending |-> !irq_act)
    else $error("Level interrupt active with nothing pending");

  a_pulse_load: assert property (
    c_reg.ctrl[CTRL_PULSE_BIT] && new_event |=> c_reg.pulse_cnt == PULSE_LOAD)
    else $error("Pulse counter not loaded on event");

  a_pulse_end: assert property (
    c_reg.ctrl[CTRL_PULSE_BIT] && c_reg.pulse_cnt == '0 |-> !irq_act)
    else $error("Pulse interrupt active after its time");

  a_pulse_count: assert property (
    c_reg.pulse_cnt != '0 && !(c_reg.ctrl[CTRL_PULSE_BIT] && new_event) |=>
    c_reg.pulse_cnt == $past(c_reg.pulse_cnt) - 1'b1)
    else $error("Pulse counter did not count down");

  a_system_sources: assert property (
    sys_events.active_to_sleep_event || sys_events.sleep_to_active_event ||
    sys_events.calibration_done |=> c_reg.src_sta[SRC_SYSTEM_BIT])
    else $error("System event not summarised in status");

  a_queue_flag: assert property (
    sys_events.queue_data_ready |=> c_reg.src_sta[SRC_QUEUE_BIT])
    else $error("Queue data not recorded in status");

  a_por_flag: assert property (
    !c_reg.por_done |=> c_reg.src_sta[SRC_POR_BIT])
    else $error("Power-on event not recorded in status");

  a_status_keep: assert property (
    !wr && src_set == 8'h00 |=> $stable(c_reg.src_sta))
    else $error("Status changed with no event and no write");

  a_pin_quiet: assert property (
    !wr && (pin_change & c_reg.pin_irq_allow_bits) == 8'h00 |=>
    $stable(c_reg.src_sta[SRC_PIN_BIT]))
    else $error("Pin summary set by a disabled pin");

  a_pin_clear: assert property (
    wr && l_reg.cmd.addr == OFS_PIN_IRQ_STATUS && l_reg.cmd.wdata[0] &&
    !pin_change[0] |=> !c_reg.pin_irq_flag_bits[0])
    else $error("Write one did not clear pin flag");

  a_monitor_read: assert property (
    access && l_reg.cmd.addr == OFS_PIN_LEVEL_LOW |=> c_reg.rdata == $past(c_reg.pin_sync2))
    else $error("Monitor read does not return pin levels");

  a_enable_write: assert property (
    wr && l_reg.cmd.addr == OFS_IRQ_SOURCE_ENABLE |=> c_reg.src_en == $past(l_reg.cmd.wdata))
    else $error("Source enable write not stored");

  a_pin_enable_write: assert property (
    wr && l_reg.cmd.addr == OFS_PIN_IRQ_ENABLE |=>
    c_reg.pin_irq_allow_bits == $past(l_reg.cmd.wdata))
    else $error("Pin enable write not stored");

  a_drive_write: assert property (
    wr && l_reg.cmd.addr == OFS_PIN_DRIVE_LOW |=> c_reg.drive == $past(l_reg.cmd.wdata))
    else $error("Drive write not stored");

  a_dir_write: assert property (
    wr && l_reg.cmd.addr == OFS_PIN_DIRECTION_LOW |=> c_reg.dir == $past(l_reg.cmd.wdata))
    else $error("Direction write not stored");

  a_drive_route: assert property (
    c_reg.func[7] |=> pin_out[7] == $past(c_reg.drive[7]))
    else $error("Pin without alternate use does not follow drive");

  a_touch_route: assert property (
    !c_reg.func[0] |=> pin_out[0] == $past(touch_status[0]))
    else $error("Touch channel not routed to pin");

  a_pwm_route: assert property (
    c_reg.func[0] && alternate_function_bits[0] |=> pin_out[0] == $past(pwm_out[0]))
    else $error("PWM channel not routed to pin");

  a_pwm_pin_three: assert property (
    c_reg.func[3] && alternate_function_bits[3] |=> pin_out[3] == $past(pwm_out[3]))
    else $error("PWM channel three not on pin three");

  c_pulse_mode: cover property (c_reg.ctrl[CTRL_PULSE_BIT] && new_event);
  c_level_irq:  cover property (!c_reg.ctrl[CTRL_PULSE_BIT] && pending ##1 !pending);
  c_pwm_route:  cover property (c_reg.func[0] && alternate_function_bits[0] && c_reg.dir[0]);
  c_set_clear:  cover property (wr && l_reg.cmd.addr == OFS_PIN_IRQ_STATUS && |pin_change);

endmodule // irq_gpio_ctrl

// File: inc/irq_gpio_pkg.sv
/*
  Shared constants and carrier types of the interrupt and pin controller.
  Assumes a byte-wide register port and an eight-pin port.
*/
package irq_gpio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_IRQ_OUTPUT_CONTROL = 8'h08;
  localparam logic [7:0] OFS_IRQ_SOURCE_ENABLE  = 8'h09;
  localparam logic [7:0] OFS_IRQ_SOURCE_STATUS  = 8'h0a;
  localparam logic [7:0] OFS_PIN_IRQ_ENABLE     = 8'h0b;
  localparam logic [7:0] OFS_PIN_IRQ_ENABLE_HI  = 8'h0c;
  localparam logic [7:0] OFS_PIN_IRQ_STATUS     = 8'h0d;
  localparam logic [7:0] OFS_PIN_IRQ_STATUS_HI  = 8'h0e;
  localparam logic [7:0] OFS_PIN_LEVEL_LOW      = 8'h10;
  localparam logic [7:0] OFS_PIN_LEVEL_HIGH     = 8'h11;
  localparam logic [7:0] OFS_PIN_DRIVE_LOW      = 8'h12;
  localparam logic [7:0] OFS_PIN_DRIVE_HIGH     = 8'h13;
  localparam logic [7:0] OFS_PIN_DIRECTION_LOW  = 8'h14;
  localparam logic [7:0] OFS_PIN_DIRECTION_HIGH = 8'h15;
  localparam logic [7:0] OFS_PIN_FUNCTION_LOW   = 8'h16;
  localparam logic [7:0] OFS_PIN_FUNCTION_HIGH  = 8'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int         CTRL_GLOBAL_EN_BIT = 0;
  localparam int         CTRL_PULSE_BIT     = 1;
  localparam int         CTRL_POLARITY_BIT  = 2;
  localparam logic [7:0] CTRL_WRITE_MASK    = 8'h07;
  localparam int         SRC_POR_BIT        = 0;
  localparam int         SRC_QUEUE_BIT      = 1;
  localparam int         SRC_SYSTEM_BIT     = 2;
  localparam int         SRC_PWM_LSB        = 3;
  localparam int         SRC_PIN_BIT        = 7;
  localparam int         PWM_PIN_COUNT      = 4;
  localparam logic [7:0] REG_RESET          = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS   = 5_000;
  localparam int PULSE_TIME_US   = 200;
  localparam int PULSE_CYCLES    = (PULSE_TIME_US * 1_000_000) / CLK_PERIOD_PS;
  localparam int PULSE_CNT_WIDTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_cmd_type;

  typedef struct packed {
    logic       active_to_sleep_event;
    logic       sleep_to_active_event;
    logic       calibration_done;
    logic       queue_data_ready;
    logic [3:0] pwm_done;
  } sys_events_type;

  typedef struct packed {
    logic        req_tgl;
    logic        ack_sync1;
    logic        ack_sync2;
    logic        busy;
    logic        rvalid;
    logic [7:0]  rdata;
    reg_cmd_type cmd;
  } link_state_type;

  typedef struct packed {
    logic [7:0]                 pin_sync1;
    logic [7:0]                 pin_sync2;
    logic [7:0]                 pin_prev;
    logic                       req_sync1;
    logic                       req_sync2;
    logic                       req_seen;
    logic                       ack_tgl;
    logic [7:0]                 rdata;
    logic                       por_done;
    logic [7:0]                 ctrl;
    logic [7:0]                 src_en;
    logic [7:0]                 src_sta;
    logic [7:0]                 pin_irq_allow_bits;
    logic [7:0]                 pin_irq_flag_bits;
    logic [7:0]                 drive;
    logic [7:0]                 dir;
    logic [7:0]                 func;
    logic [PULSE_CNT_WIDTH-1:0] pulse_cnt;
    logic                       irq_pin;
    logic [7:0]                 pin_out;
    logic [7:0]                 pin_oe;
  } core_state_type;

endpackage

// File: verification/host_model.sv
/*
  Host side model: issues byte register accesses on the link clock.
  Assumes one answer pulse for every taken request.
*/
`timescale 1ns/1ps

module host_model
  import irq_gpio_pkg::*;
(
  input  wire logic                 link_clk,
  input  wire logic                 arst_n,
  output logic                      reg_req,
  output irq_gpio_pkg::reg_cmd_type reg_cmd,
  input  wire logic                 reg_busy,
  input  wire logic                 reg_rvalid,
  input  wire logic [7:0]           reg_rdata
);
  initial begin
    reg_req = 1'b0;
    reg_cmd = '0;
  end

  ////////////////////////////////////////
  // Command held until the answer; then scrambled, not left stale
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    int   n;
    logic seen_busy;
    n = 0;
    seen_busy = 1'b0;
    @(posedge link_clk);
    reg_req <= 1'b1;
    reg_cmd <= '{write: w, addr: a, wdata: d};
    @(posedge link_clk);
    reg_req <= 1'b0;
    do begin
      @(posedge link_clk);
      n++;
      seen_busy = seen_busy | (reg_busy === 1'b1);
    end while (reg_rvalid !== 1'b1 && n < 40);
    q  = reg_rdata;
    ok = (reg_rvalid === 1'b1) && seen_busy && (reg_busy === 1'b0);
    reg_cmd <= ~reg_cmd;
  endtask
endmodule // host_model

// File: verification/tb_top.sv
/*
  Self-checking bench of the interrupt and pin controller.
  Assumes the host model on the link side and a short pulse length.
*/
`timescale 1ns/1ps

module tb_top;
  import irq_gpio_pkg::*;
  localparam int PLEN = 20;
  logic           core_clk, link_clk, arst_n, reg_req, reg_busy, reg_rvalid, irq_pin;
  reg_cmd_type    reg_cmd;
  sys_events_type sys_events;
  logic [7:0]     reg_rdata, touch_status, pin_in, pin_out, pin_oe;
  logic [3:0]     pwm_out, alt_bits;
  int             failures, n_checks;

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  // Link clock offset so edges never line up with the core clock
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #16 link_clk = ~link_clk;
  end

  irq_gpio_ctrl #(.PULSE_LEN(PLEN)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .link_clk(link_clk), .reg_req(reg_req), .reg_cmd(reg_cmd), .reg_busy(reg_busy),
    .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .sys_events(sys_events),
    .pwm_out(pwm_out), .alternate_function_bits(alt_bits), .touch_status(touch_status),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_pin(irq_pin));

  host_model host (.link_clk(link_clk), .arst_n(arst_n), .reg_req(reg_req),
    .reg_cmd(reg_cmd), .reg_busy(reg_busy), .reg_rvalid(reg_rvalid),
    .reg_rdata(reg_rdata));

  ////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       ok;
    host.xfer(1'b0, a, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h01);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       ok;
    host.xfer(1'b1, a, d, q, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic irq_is(input logic v);
    chk({7'h00, irq_pin}, {7'h00, v});
  endtask
  task automatic ev(input sys_events_type e);
    @(posedge core_clk);
    sys_events <= e;
    @(posedge core_clk);
    sys_events <= '0;
  endtask

  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    irq_is(1'b1);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h01);
    rd(8'h0b, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h14, 8'h00);
    chk(pin_oe, 8'h00);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h07);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
  endtask

  task automatic t_level;
    wr(8'h0a, 8'hff);
    wr(8'h09, 8'h04);
    ev(8'h20);
    cyc(6);
    irq_is(1'b1);
    rd(8'h0a, 8'h04);
    wr(8'h08, 8'h01);
    cyc(6);
    irq_is(1'b0);
    wr(8'h0a, 8'h00);
    rd(8'h0a, 8'h04);
    irq_is(1'b0);
    wr(8'h0a, 8'h04);
    cyc(6);
    irq_is(1'b1);
    for (int k = 0; k < 2; k++) begin
      ev(8'h80 >> k);
      rd(8'h0a, 8'h04);
      wr(8'h0a, 8'h04);
    end
    wr(8'h09, 8'h00);
    ev(8'h01);
    cyc(6);
    irq_is(1'b1);
    rd(8'h0a, 8'h08);
    wr(8'h0a, 8'h08);
  endtask

  task automatic t_pulse;
    wr(8'h09, 8'h78);
    wr(8'h08, 8'h07);
    for (int k = 0; k < 4; k++) begin
      ev(8'h01 << k);
      cyc(5);
      irq_is(1'b1);
      cyc(PLEN + 5);
      irq_is(1'b0);
      rd(8'h0a, 8'h08 << k);
      wr(8'h0a, 8'h08 << k);
    end
    wr(8'h08, 8'h00);
    @(posedge core_clk);
    sys_events.queue_data_ready <= 1'b1;
    rd(8'h0a, 8'h02);
    wr(8'h0a, 8'h02);
    rd(8'h0a, 8'h02);
    @(posedge core_clk);
    sys_events.queue_data_ready <= 1'b0;
    wr(8'h0a, 8'h02);
    rd(8'h0a, 8'h00);
  endtask

  task automatic t_pins;
    wr(8'h14, 8'hff);
    wr(8'h12, 8'ha5);
    wr(8'h16, 8'hff);
    cyc(4);
    chk(pin_oe, 8'hff);
    chk(pin_out, 8'ha5);
    @(posedge core_clk);
    alt_bits <= 4'hf;
    pwm_out <= 4'h6;
    touch_status <= 8'h3c;
    cyc(4);
    chk(pin_out, 8'ha6);
    wr(8'h16, 8'h0f);
    cyc(4);
    chk(pin_out, 8'h36);
    wr(8'h14, 8'h00);
    cyc(4);
    chk(pin_oe, 8'h00);
  endtask

  task automatic t_pin_irq;
    wr(8'h0b, 8'h01);
    wr(8'h09, 8'h80);
    wr(8'h08, 8'h01);
    @(posedge core_clk);
    pin_in <= 8'h81;
    cyc(8);
    rd(8'h0d, 8'h81);
    rd(8'h0a, 8'h80);
    rd(8'h10, 8'h81);
    irq_is(1'b0);
    wr(8'h0d, 8'h01);
    rd(8'h0d, 8'h80);
    wr(8'h0a, 8'h80);
    cyc(6);
    irq_is(1'b1);
    @(posedge core_clk);
    pin_in <= 8'h01;
    cyc(8);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h01);
  endtask

  ////////////////////////////////////////
  // Run control
  task automatic close_out;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Whole run needs about 12 us; about sixteen times that is a hang
  initial begin
    #200_000;
    failures++;
    close_out();
  end

  initial begin
    failures = 0;
    n_checks = 0;
    arst_n = 1'b0;
    sys_events = '0;
    pwm_out = 4'h0;
    alt_bits = 4'h0;
    touch_status = 8'h00;
    pin_in = 8'h00;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge link_clk);
    t_reset();
    t_level();
    t_pulse();
    t_pins();
    t_pin_irq();
    close_out();
  end
endmodule // tb_top
